// [rtl/sfr_pkg.sv]
// Shared types and constants for the serial port fault and reset block.
// Assumes a single bus clock domain and a byte-wide serial shifter.
package sfr_pkg;

  // Control bits that software writes through the control strobe.
  typedef struct packed {
    logic rx_irq_enable;
    logic master_select;
    logic clock_polarity;
    logic clock_phase;
    logic port_enable;
    logic tx_irq_enable;
    logic error_irq_enable;
    logic mode_fault_enable;
  } sfr_ctrl_t;

  // Status flags that hardware sets.
  typedef struct packed {
    logic rx_full_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
  } sfr_flags_t;

  // One cycle register access strobes from the processor side.
  typedef struct packed {
    logic status_rd;
    logic ctrl_wr;
    logic data_rd;
    logic data_wr;
  } sfr_access_t;

  // Control state after a system reset: master role, phase one.
  localparam sfr_ctrl_t CTRL_RESET = '{
    rx_irq_enable: 1'b0, master_select: 1'b1, clock_polarity: 1'b0,
    clock_phase: 1'b1, port_enable: 1'b0, tx_irq_enable: 1'b0,
    error_irq_enable: 1'b0, mode_fault_enable: 1'b0};
  localparam sfr_flags_t FLAGS_RESET = 4'h1;

  // Bits in a byte and the sample count at which overrun is judged.
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] OVR_SAMPLE  = 4'h7;
  localparam int         SCK_HALF_DF = 4;

endpackage

// [rtl/sfr_spi_port.sv]
// Serial port core: mode fault detection, flags, interrupt requests,
// partial reset, wait and break handling, and a byte shifter.
// Assumes pins arrive asynchronously and access strobes are synchronous.
// How it works
// - Master drives clock and MOSI, reads MISO; slave does the reverse.
// - Fault flag sets on master select low, or slave deselect mid-transfer.
// - Disabling fault detection keeps the flag; once cleared it stays clear.
// - Master fault disables port, sets tx empty, clears counter, frees pins.
// - Phase zero slave transfer runs from select fall to clock idle after bit eight.
// - Phase one slave transfer runs from first clock edge to idle after last bit.
// - Phase zero select then deselect faults; phase one does not.
// - A fault never alters master role; role is ignored while disabled.
// - Slave fault only requests the error interrupt, nothing else.
// - Deselected slave floats MISO and ignores all clock edges.
// - Fault flag clears by status read then control write, absent fault.
// - Transmit request needs tx empty, its enable, port enabled, no dma.
// - Receive request is rx full and its enable, no dma, any enable state.
// - One error enable gates overrun and fault onto the shared request.
// - Rx full clears by status read then data read.
// - Tx empty clears only by a data write.
// - Rx full sets on each received byte; tx empty on each shifter load.
// - Disabled port holds tx empty, aborts, clears shifter and counter.
// - Control bits and three flags are reset only by system reset, not by partial reset.
// - In wait the port runs, accesses are blocked, requests wake.
// - Protected break freezes flags against accesses; pending steps survive.
// - Protected break discards data writes.
// - Overrun sets if rx still full at the seventh sample of a byte.
// - Reset selects master role.
`timescale 1ns/1ps
module sfr_spi_port
  import sfr_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_DF
)(
  // Clock, reset and clock enable.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // Processor access strobes and write data.
  input  wire sfr_access_t acc,
  input  wire sfr_ctrl_t   ctrl_wdata,
  input  wire logic [7:0]  tx_wdata,
  input  wire logic        dma_select,
  input  wire logic        wait_mode,
  input  wire logic        break_state,
  input  wire logic        break_clear_enable,
  // Register contents seen by the processor.
  output sfr_ctrl_t        ctrl_q,
  output sfr_flags_t       flags_q,
  output logic [7:0]       rx_data,
  output logic             port_owns_pins,
  // Interrupt requests.
  output logic             tx_irq,
  output logic             rx_err_irq,
  output logic             wake_req,
  // Serial pins; output enables are active low.
  input  wire logic        slave_sel_n_pin,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe_n,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe_n,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe_n
);

  // Width of the divider that counts bus cycles in one master clock half period.
  localparam int DW = (SCK_HALF < 2) ? 1 : $clog2(SCK_HALF);

  generate
    if (SCK_HALF < 1) begin : g_bad
      $error("SCK_HALF must be at least one");
    end
    if (OVR_SAMPLE >= BYTE_BITS) begin : g_bad_ovr
      $error("overrun sample must fall inside the byte");
    end
  endgenerate

  typedef struct packed {
    logic [1:0]    ss_sy;
    logic [1:0]    sck_sy;
    logic [1:0]    mosi_sy;
    logic [1:0]    miso_sy;
    sfr_ctrl_t     ctrl;
    sfr_flags_t    flg;
    logic          mf_arm;
    logic          rx_arm;
    logic          active;
    logic          s_prev;
    logic          ss_prev;
    logic          ms_clk;
    logic          out_bit;
    logic [3:0]    bits;
    logic [7:0]    shift;
    logic [7:0]    tx_buf;
    logic [7:0]    rx_buf;
    logic [DW-1:0] div;
  } sfr_state_t;

  sfr_state_t r;
  sfr_state_t n;

  logic       acc_ok;
  logic       protect;
  logic       ss_low;
  logic       s_now;
  logic       edge_ev;
  logic       lead;
  logic       trail;
  logic       master_role_bit;
  logic       slv;
  logic       fault;
  logic       sample;
  logic [7:0] load_val;

  // Shared conditions derived from the registered state.
  always_comb begin
    acc_ok   = !wait_mode;
    protect  = break_state && !break_clear_enable;
    ss_low   = !r.ss_sy[1];
    master_role_bit     = r.ctrl.port_enable && r.ctrl.master_select;
    slv      = r.ctrl.port_enable && !r.ctrl.master_select;
    s_now    = master_role_bit ? r.ms_clk : (r.sck_sy[1] ^ r.ctrl.clock_polarity);
    // A deselected slave sees no clock edges at all.
    edge_ev  = (s_now != r.s_prev) && (master_role_bit || (slv && ss_low));
    lead     = edge_ev && s_now;
    trail    = edge_ev && !s_now;
    sample   = r.active && (r.ctrl.clock_phase ? trail : lead);
    load_val = r.flg.tx_empty_flag ? r.shift : r.tx_buf;
    fault    = r.ctrl.mode_fault_enable &&
               ((master_role_bit && ss_low) ||
                (slv && r.active && !ss_low));
  end

  // Next state: accesses first, then hardware events so sets win.
  always_comb begin
    n = r;
    // Pins pass two flip-flops; only the second stage feeds any decision.
    n.ss_sy   = {r.ss_sy[0], slave_sel_n_pin};
    n.sck_sy  = {r.sck_sy[0], serial_clock_pin_in};
    n.mosi_sy = {r.mosi_sy[0], mosi_in};
    n.miso_sy = {r.miso_sy[0], miso_in};
    n.s_prev  = s_now;
    n.ss_prev = r.ss_sy[1];

    // Status read arms the two-step clears.
    if (acc_ok && acc.status_rd && !protect) begin
      if (r.flg.mode_fault_flag) begin
        n.mf_arm = 1'b1;
      end
      if (r.flg.rx_full_flag) begin
        n.rx_arm = 1'b1;
      end
    end

    // Control write updates control bits and completes the fault clear.
    if (acc_ok && acc.ctrl_wr) begin
      n.ctrl = ctrl_wdata;
      if (r.mf_arm && !protect) begin
        n.flg.mode_fault_flag = 1'b0;
        n.mf_arm = 1'b0;
      end
    end

    // Data read completes the receive clear, taking overrun with it.
    if (acc_ok && acc.data_rd && r.rx_arm && !protect) begin
      n.flg.rx_full_flag = 1'b0;
      n.flg.overrun_flag = 1'b0;
      n.rx_arm = 1'b0;
    end

    // Data write queues a byte unless break protection discards it.
    // A disabled port drops writes so tx empty stays set through the partial reset.
    if (acc_ok && acc.data_wr && !protect && r.ctrl.port_enable) begin
      n.tx_buf = tx_wdata;
      n.flg.tx_empty_flag = 1'b0;
    end

    // Master clock divider runs only during a transfer.
    // Restarting from zero gives every byte a full first half period.
    if (master_role_bit && r.active) begin
      if (r.div == DW'(SCK_HALF - 1)) begin
        n.div = '0;
        n.ms_clk = !r.ms_clk;
      end else begin
        n.div = r.div + 1'b1;
      end
    end else begin
      n.div = '0;
      n.ms_clk = 1'b0;
    end

    // Transfer start for master, and for each slave phase.
    if (!r.active) begin
      if (master_role_bit && !r.flg.tx_empty_flag) begin
        n.active = 1'b1;
        n.shift = r.tx_buf;
        n.out_bit = r.tx_buf[7];
        n.flg.tx_empty_flag = 1'b1;
        n.bits = '0;
      end else if (slv && ss_low && (r.ctrl.clock_phase ? lead
                   : r.ss_prev)) begin
        n.active = 1'b1;
        n.shift = load_val;
        n.out_bit = load_val[7];
        n.flg.tx_empty_flag = 1'b1;
        n.bits = '0;
      end
    end else begin
      // Drive the next bit on the shifting edge.
      if (r.ctrl.clock_phase ? lead : trail) begin
        n.out_bit = r.shift[7];
      end
      if (sample) begin
        n.shift = {r.shift[6:0], master_role_bit ? r.miso_sy[1] : r.mosi_sy[1]};
        n.bits = r.bits + 1'b1;
        if ((r.bits + 1'b1) == OVR_SAMPLE && r.flg.rx_full_flag) begin
          n.flg.overrun_flag = 1'b1;
        end
      end
      // Byte ends when the clock rests at idle after the last sample.
      // After an overrun the move is skipped so the unread byte survives.
      if (r.bits == BYTE_BITS && !s_now) begin
        n.active = 1'b0;
        if (!r.flg.overrun_flag) begin
          n.rx_buf = r.shift;
          n.flg.rx_full_flag = 1'b1;
        end
      end
      // A slave deselect ends the byte; the fault is raised below.
      if (slv && !ss_low) begin
        n.active = 1'b0;
      end
    end

    // Mode fault: a master stops, a slave only flags.
    // Placed after the clears so a fault inside a clearing sequence keeps the flag.
    if (fault) begin
      n.flg.mode_fault_flag = 1'b1;
      n.mf_arm = 1'b0;
      if (master_role_bit) begin
        n.ctrl.port_enable = 1'b0;
        n.flg.tx_empty_flag = 1'b1;
        n.active = 1'b0;
        n.bits = '0;
      end
    end

    // Partial reset while disabled; control and sticky flags survive.
    // Evaluated last so a disabled port can neither start nor keep a transfer.
    if (!r.ctrl.port_enable) begin
      n.flg.tx_empty_flag = 1'b1;
      n.active = 1'b0;
      n.bits = '0;
      n.shift = '0;
      n.out_bit = 1'b0;
    end
  end

  // State register with system reset and clock enable.
  // Synchronisers reset to idle levels so no false select edge follows reset.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.ss_sy <= 2'h3;
      r.ss_prev <= 1'b1;
      r.ctrl <= CTRL_RESET;
      r.flg <= FLAGS_RESET;
    end else if (clk_en) begin
      r <= n;
    end
  end

  // Register views and interrupt requests.
  always_comb begin
    ctrl_q         = r.ctrl;
    flags_q        = r.flg;
    rx_data        = r.rx_buf;
    port_owns_pins = r.ctrl.port_enable;
    tx_irq         = r.flg.tx_empty_flag && r.ctrl.tx_irq_enable &&
                     r.ctrl.port_enable && !dma_select;
    rx_err_irq     = (r.flg.rx_full_flag && r.ctrl.rx_irq_enable &&
                      !dma_select) ||
                     (r.ctrl.error_irq_enable &&
                      (r.flg.overrun_flag || r.flg.mode_fault_flag));
    wake_req       = tx_irq || rx_err_irq;
  end

  // Pin drivers: enables low while this end drives the pin.
  // Data outputs follow the shifter regardless; only the enables decide who drives.
  always_comb begin
    serial_clock_pin_out  = r.ms_clk ^ r.ctrl.clock_polarity;
    serial_clock_pin_oe_n = !master_role_bit;
    mosi_out              = r.out_bit;
    mosi_oe_n             = !master_role_bit;
    miso_out              = r.out_bit;
    miso_oe_n             = !(slv && ss_low);
  end

endmodule

// [testbench/sfr_spi_port_sva.sv]
// Checker for the serial port: request gating, fault side effects, pins.
// Assumes it is bound to sfr_spi_port and sees only its ports.
`timescale 1ns/1ps
module sfr_spi_port_sva
  import sfr_pkg::*;
(
  // Clock, reset and inputs.
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire sfr_access_t acc,
  input wire logic        dma_select,
  input wire logic        break_state,
  input wire logic        break_clear_enable,
  input wire logic        slave_sel_n_pin,
  // Observed outputs.
  input wire sfr_ctrl_t   ctrl_q,
  input wire sfr_flags_t  flags_q,
  input wire logic        port_owns_pins,
  input wire logic        tx_irq,
  input wire logic        rx_err_irq,
  input wire logic        wake_req,
  input wire logic        miso_oe_n
);
  // Every check runs on the bus clock and rests during reset.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_tx_req_gate: assert property (tx_irq == (flags_q.tx_empty_flag && ctrl_q.tx_irq_enable
    && ctrl_q.port_enable && !dma_select)) else $error("transmit request gating wrong");
  chk_rx_req_level: assert property (rx_err_irq == ((flags_q.rx_full_flag && ctrl_q.rx_irq_enable
    && !dma_select) || (ctrl_q.error_irq_enable && (flags_q.overrun_flag || flags_q.mode_fault_flag))))
    else $error("receive or error request level wrong");
  chk_wake_follows: assert property (wake_req == (tx_irq || rx_err_irq))
    else $error("wake request does not follow the requests");
  chk_off_tx_empty: assert property (!ctrl_q.port_enable [*2] |-> flags_q.tx_empty_flag)
    else $error("tx empty low while port disabled");
  chk_master_fault_off: assert property ($rose(flags_q.mode_fault_flag) && $past(ctrl_q.master_select)
    |-> !ctrl_q.port_enable && flags_q.tx_empty_flag && !port_owns_pins) else $error("master fault effects missing");
  chk_slave_fault_keep: assert property ($rose(flags_q.mode_fault_flag) && !$past(ctrl_q.master_select)
    && !$past(acc.ctrl_wr) |-> $stable(ctrl_q)) else $error("slave fault altered control bits");
  chk_fault_held_off: assert property (!ctrl_q.mode_fault_enable && !flags_q.mode_fault_flag
    && !acc.ctrl_wr |=> !flags_q.mode_fault_flag) else $error("fault flag set while detection off");
  chk_deselect_float: assert property (slave_sel_n_pin [*6] |-> miso_oe_n)
    else $error("miso driven while deselected");
  chk_break_no_write: assert property (break_state && !break_clear_enable && acc.data_wr
    && flags_q.tx_empty_flag |=> flags_q.tx_empty_flag) else $error("data write taken during break");
endmodule

bind sfr_spi_port sfr_spi_port_sva sfr_spi_port_sva_inst (
  .sys_clk(sys_clk), .rst(rst), .acc(acc), .dma_select(dma_select), .break_state(break_state),
  .break_clear_enable(break_clear_enable), .slave_sel_n_pin(slave_sel_n_pin), .ctrl_q(ctrl_q),
  .flags_q(flags_q), .port_owns_pins(port_owns_pins), .tx_irq(tx_irq), .rx_err_irq(rx_err_irq),
  .wake_req(wake_req), .miso_oe_n(miso_oe_n));

// [testbench/sfr_far_master.sv]
// Far-end master model: selects the port and clocks bits every 400 ns.
// Assumes clock idle low, one task call at a time, each begun off the bus clock's rising edge.
`timescale 1ns/1ps
module sfr_far_master (
  // Serial lines towards the port.
  output logic      ss_n,
  output logic      sck,
  output logic      mosi,
  // Serial line back from the port.
  input  wire logic miso
);
  // Bits seen on the return line during the last byte.
  logic [7:0] got;
  // Idle: deselected and the clock stands still.
  initial begin
    ss_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
    got  = 8'h00;
  end
  // Selects, leaving time for the port's synchronisers.
  task automatic sel();
    ss_n = 1'b0;
    #400;
  endtask
  // Releases select; the data line stops showing the last bit.
  task automatic desel();
    ss_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
  // Clocks one byte, most significant bit first.
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #100 sck = 1'b1;
      #200 sck = 1'b0;
      got = {got[6:0], miso};
      #100;
    end
    #200;
  endtask
endmodule

// [testbench/test_sfr_spi_port.sv]
// Self-checking bench for the serial port fault, request and reset block.
// Assumes the far-end master model and the bound checker are compiled too.
`timescale 1ns/1ps
module test_sfr_spi_port
  import sfr_pkg::*;
;
  logic        sys_clk, rst, dma_select, wait_mode, break_state;
  sfr_access_t acc;
  sfr_ctrl_t   ctrl_wdata;
  logic [7:0]  tx_wdata, rx_data;
  sfr_ctrl_t   ctrl_q;
  sfr_flags_t  flags_q;
  logic        owns, tx_irq, rx_err_irq, wake_req, sck_oe_n, mosi_oe_n, miso_oe_n;
  logic        ss_n, far_sck, far_mosi, far_miso, sck_out, mosi_out, miso_out;
  int          miscompares, checked, sck_rises;

  sfr_spi_port #(.SCK_HALF(4)) sfr_spi_port_inst (
    .sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .acc(acc), .ctrl_wdata(ctrl_wdata), .tx_wdata(tx_wdata),
    .dma_select(dma_select), .wait_mode(wait_mode), .break_state(break_state), .break_clear_enable(1'b0),
    .ctrl_q(ctrl_q), .flags_q(flags_q), .rx_data(rx_data), .port_owns_pins(owns), .tx_irq(tx_irq),
    .rx_err_irq(rx_err_irq), .wake_req(wake_req), .slave_sel_n_pin(ss_n), .serial_clock_pin_in(far_sck),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe_n(sck_oe_n), .mosi_in(far_mosi), .mosi_out(mosi_out),
    .mosi_oe_n(mosi_oe_n), .miso_in(mosi_out), .miso_out(miso_out), .miso_oe_n(miso_oe_n));
  sfr_far_master sfr_far_master_inst (.ss_n(ss_n), .sck(far_sck), .mosi(far_mosi), .miso(far_miso));
  // Master data loops back to its own input; a floating slave output reads as a pulled-up line.
  assign far_miso = miso_oe_n ? 1'b1 : miso_out;
  // Counts rising edges of the master clock output.
  always @(posedge sck_out) begin
    sck_rises++;
  end

  // Bus clock of 50 ns.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Counts a comparison and reports a mismatch.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits edges, then moves to a falling edge where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // One access strobe; c is both control and transmit data.
  task automatic access(input logic [3:0] a, input logic [7:0] c);
    @(posedge sys_clk);
    acc        <= a;
    ctrl_wdata <= c;
    tx_wdata   <= c;
    @(posedge sys_clk);
    acc <= '0;
    settle(3);
  endtask
  // A selected byte from the far end.
  task automatic frame(input logic [7:0] b);
    sfr_far_master_inst.sel();
    sfr_far_master_inst.xfer(b);
    sfr_far_master_inst.desel();
    settle(4);
  endtask
  // Drives dma_select for one settled check of both requests.
  task automatic dma_look(input logic [7:0] exp);
    @(posedge sys_clk);
    dma_select <= 1'b1;
    settle(1);
    check({tx_irq, rx_err_irq}, exp);
    @(posedge sys_clk);
    dma_select <= 1'b0;
    @(negedge sys_clk);
  endtask
  // Reset state of controls, flags, pins and requests.
  task automatic t_reset();
    check(ctrl_q, CTRL_RESET);
    check(flags_q, FLAGS_RESET);
    check({sck_oe_n, mosi_oe_n, miso_oe_n, tx_irq, rx_err_irq}, 8'h1c);
  endtask
  // Master byte, dma gating, wait-mode refusal and receive clear.
  task automatic t_master();
    access(4'h4, 8'h5f);
    check({sck_oe_n, mosi_oe_n, miso_oe_n, tx_irq, wake_req}, 8'h07);
    dma_look(8'h00);
    @(posedge sys_clk);
    wait_mode <= 1'b1;
    access(4'h4, 8'h00);
    check(ctrl_q, 8'h5f);
    @(posedge sys_clk);
    wait_mode <= 1'b0;
    access(4'h1, 8'h96);
    settle(70);
    check({flags_q, rx_data[3:0]}, 8'h96);
    check(rx_data, 8'h96);
    check(8'(sck_rises), 8'h08);
    access(4'h8, 8'h00);
    access(4'h2, 8'h00);
    check(flags_q, 8'h01);
  endtask
  // Data write during a protected break is dropped.
  task automatic t_break();
    @(posedge sys_clk);
    break_state <= 1'b1;
    access(4'h1, 8'h11);
    settle(60);
    check(flags_q, 8'h01);
    @(posedge sys_clk);
    break_state <= 1'b0;
  endtask
  // Select low on an enabled master.
  task automatic t_mfault();
    settle(0);
    sfr_far_master_inst.sel();
    settle(8);
    check(flags_q, 8'h03);
    check({ctrl_q.port_enable, ctrl_q.master_select, owns, tx_irq, rx_err_irq}, 8'h09);
    sfr_far_master_inst.desel();
    access(4'h8, 8'h00);
    access(4'h4, 8'h9b);
    check(flags_q, 8'h01);
  endtask
  // Phase one slave: empty select, two bytes, overrun, disable, clear.
  task automatic t_slave();
    sfr_far_master_inst.sel();
    sfr_far_master_inst.desel();
    settle(4);
    check(flags_q, 8'h01);
    access(4'h1, 8'hc3);
    frame(8'ha5);
    check({flags_q, rx_err_irq}, 8'h13);
    check(rx_data, 8'ha5);
    check(sfr_far_master_inst.got, 8'hc3);
    dma_look(8'h00);
    frame(8'h3c);
    check({flags_q, rx_data[3:0]}, 8'hd5);
    check(sfr_far_master_inst.got, 8'ha5);
    access(4'h4, 8'h93);
    check({flags_q, rx_err_irq}, 8'h1b);
    access(4'h8, 8'h00);
    access(4'h2, 8'h00);
    check(flags_q, 8'h01);
  endtask
  // Phase zero slave: ignored clocks, empty select fault, clear rules.
  task automatic t_sfault();
    access(4'h4, 8'h8b);
    sfr_far_master_inst.xfer(8'h5a);
    settle(4);
    check({flags_q, miso_oe_n}, 8'h03);
    sfr_far_master_inst.sel();
    check(miso_oe_n, 1'b0);
    sfr_far_master_inst.desel();
    settle(4);
    check({flags_q, ctrl_q.port_enable, ctrl_q.master_select, rx_err_irq}, 8'h1d);
    access(4'h4, 8'h8a);
    check(flags_q, 8'h03);
    access(4'h8, 8'h00);
    @(posedge sys_clk);
    break_state <= 1'b1;
    access(4'h4, 8'h8a);
    check(flags_q, 8'h03);
    @(posedge sys_clk);
    break_state <= 1'b0;
    access(4'h4, 8'h8a);
    check(flags_q, 8'h01);
    access(4'h1, 8'he7);
    frame(8'h69);
    check(flags_q, 8'h09);
    check(rx_data, 8'h69);
    check(sfr_far_master_inst.got, 8'he7);
    sfr_far_master_inst.sel();
    sfr_far_master_inst.desel();
    settle(4);
    check(flags_q, 8'h09);
  endtask
  // Ends the run with the counts and the verdict.
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence: reset for five cycles, then each scenario.
  initial begin
    rst         = 1'b1;
    acc         = '0;
    ctrl_wdata  = '0;
    tx_wdata    = 8'h00;
    dma_select  = 1'b0;
    wait_mode   = 1'b0;
    break_state = 1'b0;
    miscompares = 0;
    checked     = 0;
    sck_rises   = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    settle(1);
    t_reset();
    t_master();
    t_break();
    t_mfault();
    t_slave();
    t_sfault();
    final_report();
  end
  // Watchdog well beyond the expected run length.
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
endmodule
